// ---- pcx_pkg.sv ----
// ****************************************************************
// Crossbar constants
// ****************************************************************
package pcx_pkg;

  // Widths and counts
  localparam int DATA_W = 8;
  localparam int NUM_PINS = 32;
  localparam int XBAR_PINS = 24;
  localparam int NUM_SIG = 24;
  localparam int SIG_W = 5;
  localparam int POS_W = 6;
  localparam int PCA_SIGS = 5;
  localparam logic [2:0] PCA_MAX_CODE = 3'h5;

  // Register addresses and reset values
  localparam logic [7:0] ADDR_SEL_BUS_PCA = 8'hE1;
  localparam logic [7:0] ADDR_SEL_TIMERS_IRQ = 8'hE2;
  localparam logic [7:0] ADDR_ENABLE_PULLUP = 8'hE3;
  localparam logic [7:0] RST_SEL_BUS_PCA = 8'h00;
  localparam logic [7:0] RST_SEL_TIMERS_IRQ = 8'h00;
  localparam logic [7:0] RST_ENABLE_PULLUP = 8'h00;
  localparam logic [7:0] ENABLE_PULLUP_RW_MASK = 8'hC1;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // Bus and counter-array select fields
  localparam int B0_MGMT = 0;
  localparam int B0_SPI = 1;
  localparam int B0_UART = 2;
  localparam int B0_PCA_LO = 3;
  localparam int B0_PCA_HI = 5;
  localparam int B0_ECI = 6;
  localparam int B0_CMPA = 7;

  // Timer and irq select fields
  localparam int B1_CMPB = 0;
  localparam int B1_T0 = 1;
  localparam int B1_IRQ0 = 2;
  localparam int B1_T1 = 3;
  localparam int B1_IRQ1 = 4;
  localparam int B1_T2 = 5;
  localparam int B1_T2EX = 6;
  localparam int B1_SYSCLK = 7;

  // Enable and pull-up fields
  localparam int B2_ADC_START = 0;
  localparam int B2_GLOBAL_EN = 6;
  localparam int B2_PULLUP_DIS = 7;

  // Function signals in priority order
  localparam int SIG_SDA = 0;
  localparam int SIG_SCL = 1;
  localparam int SIG_SCK = 2;
  localparam int SIG_NSS = 5;
  localparam int SIG_TX = 6;
  localparam int SIG_RX = 7;
  localparam int SIG_CAPTURE_COMPARE_SIGNAL_0 = 8;
  localparam int SIG_ECI = 13;
  localparam int SIG_CMPA = 14;
  localparam int SIG_CMPB = 15;
  localparam int SIG_T0 = 16;
  localparam int SIG_IRQ0 = 17;
  localparam int SIG_T1 = 18;
  localparam int SIG_IRQ1 = 19;
  localparam int SIG_T2 = 20;
  localparam int SIG_T2EX = 21;
  localparam int SIG_SYSCLK = 22;
  localparam int SIG_ADC_START = 23;

  // Fixed management bus pins
  localparam int PIN_SDA = 0;
  localparam int PIN_SCL = 1;

  // Idle levels
  localparam logic [NUM_PINS-1:0] PINS_HIGH = 32'hFFFFFFFF;
  localparam logic [NUM_PINS-1:0] PINS_LOW = 32'h00000000;
  localparam logic [NUM_SIG-1:0] SIGS_HIGH = 24'hFFFFFF;

endpackage : pcx_pkg

// ---- pcx_pin_if.sv ----
`timescale 1ns/100ps
// ****************************************************************
// Pin sampling carrier
// ****************************************************************
interface pcx_pin_if;
  logic [pcx_pkg::NUM_PINS-1:0] raw;
  logic [pcx_pkg::NUM_PINS-1:0] level;
  logic [pcx_pkg::NUM_PINS-1:0] agree;

  // Synchroniser side
  modport syncer (input raw, output level, output agree);
  // Crossbar side
  modport user (output raw, input level, input agree);
endinterface : pcx_pin_if

// ---- pcx_pin_sync.sv ----
`timescale 1ns/100ps
// ****************************************************************
// Three-stage pin synchroniser
// ****************************************************************
module pcx_pin_sync
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  pcx_pin_if.syncer pins
);
  import pcx_pkg::*;

  logic [NUM_PINS-1:0] stage1;
  logic [NUM_PINS-1:0] stage2;
  logic [NUM_PINS-1:0] stage3;
  logic [NUM_PINS-1:0] level;
  logic [NUM_PINS-1:0] next_level;
  logic [NUM_PINS-1:0] differ;

  // Only the late stages are compared
  always_comb
  begin
    differ = stage2 ^ stage3;
    next_level = (stage3 & ~differ) | (level & differ);
  end

  // Stages idle high like a pulled-up pin
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      stage1 <= PINS_HIGH;
      stage2 <= PINS_HIGH;
      stage3 <= PINS_HIGH;
      level <= PINS_HIGH;
    end
    else
    begin
      stage1 <= pins.raw;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end

  assign pins.level = level;
  assign pins.agree = ~differ;

endmodule : pcx_pin_sync

// ---- pcx_crossbar.sv ----
`timescale 1ns/100ps
// ****************************************************************
// Overview of operation
// - Functions get fixed rank, management bus first
// - Management bus sits on port 0 bits 0,1
// - Fill pins upward, port 0 then 1, 2
// - Unselected function frees its slot downward
// - Serial bus signals always routed together
// - Leftover pins follow as plain port I/O
// - Crossbar active only when global enable set
// - Disabled crossbar leaves every pin input-only
// - Driver style follows port config bit
// - Management pins and mode-0 receive forced open-drain
// - Pull-up on open-drain pins unless disabled
// - Pull-up off while open-drain pin drives low
// - Pin level readable whatever the routing
// - Decode identical regardless of bonded pins
// ****************************************************************
module pcx_crossbar
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [pcx_pkg::DATA_W-1:0] sfr_wdata_i,
  output logic [pcx_pkg::DATA_W-1:0] sfr_rdata_o,
  input wire logic [pcx_pkg::NUM_PINS-1:0] port_latch_i,
  input wire logic [pcx_pkg::NUM_PINS-1:0] port_driver_config_i,
  input wire logic uart_mode0_i,
  input wire logic [pcx_pkg::NUM_SIG-1:0] periph_out_i,
  input wire logic [pcx_pkg::NUM_SIG-1:0] periph_oe_i,
  output logic [pcx_pkg::NUM_SIG-1:0] periph_in_o,
  input wire logic [pcx_pkg::NUM_PINS-1:0] pin_in_i,
  output logic [pcx_pkg::NUM_PINS-1:0] pin_out_o,
  output logic [pcx_pkg::NUM_PINS-1:0] pin_oe_o,
  output logic [pcx_pkg::NUM_PINS-1:0] pin_pullup_o,
  output logic [pcx_pkg::NUM_PINS-1:0] pin_level_o
);
  import pcx_pkg::*;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************

  // Counter-array signal count for a select code
  function automatic logic [2:0] pca_count(input logic [2:0] code);
    return (code > PCA_MAX_CODE) ? 3'h0 : code;
  endfunction : pca_count

  // Which function signals the select registers ask for
  function automatic logic [NUM_SIG-1:0] sig_enables(input logic [7:0] r0, input logic [7:0] r1,
                                                     input logic [7:0] r2);
    logic [NUM_SIG-1:0] en;
    logic [2:0] n;
    en = '0;
    n = pca_count(r0[B0_PCA_HI:B0_PCA_LO]);
    // Whole buses switch as one group
    en[SIG_SDA] = r0[B0_MGMT];
    en[SIG_SCL] = r0[B0_MGMT];
    for (int k = SIG_SCK; k <= SIG_NSS; k++)
    begin
      en[k] = r0[B0_SPI];
    end
    en[SIG_TX] = r0[B0_UART];
    en[SIG_RX] = r0[B0_UART];
    for (int k = 0; k < PCA_SIGS; k++)
    begin
      en[SIG_CAPTURE_COMPARE_SIGNAL_0 + k] = (3'(k) < n);
    end
    en[SIG_ECI] = r0[B0_ECI];
    en[SIG_CMPA] = r0[B0_CMPA];
    en[SIG_CMPB] = r1[B1_CMPB];
    en[SIG_T0] = r1[B1_T0];
    en[SIG_IRQ0] = r1[B1_IRQ0];
    en[SIG_T1] = r1[B1_T1];
    en[SIG_IRQ1] = r1[B1_IRQ1];
    en[SIG_T2] = r1[B1_T2];
    en[SIG_T2EX] = r1[B1_T2EX];
    en[SIG_SYSCLK] = r1[B1_SYSCLK];
    en[SIG_ADC_START] = r2[B2_ADC_START];
    return en;
  endfunction : sig_enables

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0] crossbar_select_bus_pca;
  logic [7:0] crossbar_select_timers_irq;
  logic [7:0] crossbar_enable_pullup;
  logic [7:0] next_crossbar_select_bus_pca;
  logic [7:0] next_crossbar_select_timers_irq;
  logic [7:0] next_crossbar_enable_pullup;
  logic [DATA_W-1:0] next_sfr_rdata;
  logic crossbar_global_enable;
  logic weak_pullup_disable;

  assign crossbar_global_enable = crossbar_enable_pullup[B2_GLOBAL_EN];
  assign weak_pullup_disable = crossbar_enable_pullup[B2_PULLUP_DIS];

  // Writes store, reads capture into the data register
  always_comb
  begin
    next_crossbar_select_bus_pca = crossbar_select_bus_pca;
    next_crossbar_select_timers_irq = crossbar_select_timers_irq;
    next_crossbar_enable_pullup = crossbar_enable_pullup;
    next_sfr_rdata = sfr_rdata_o;
    if (sfr_wr_i)
    begin
      case (sfr_addr_i)
        ADDR_SEL_BUS_PCA: next_crossbar_select_bus_pca = sfr_wdata_i;
        ADDR_SEL_TIMERS_IRQ: next_crossbar_select_timers_irq = sfr_wdata_i;
        ADDR_ENABLE_PULLUP: next_crossbar_enable_pullup = sfr_wdata_i & ENABLE_PULLUP_RW_MASK;
        default: next_crossbar_enable_pullup = crossbar_enable_pullup;
      endcase
    end
    if (sfr_rd_i)
    begin
      case (sfr_addr_i)
        ADDR_SEL_BUS_PCA: next_sfr_rdata = crossbar_select_bus_pca;
        ADDR_SEL_TIMERS_IRQ: next_sfr_rdata = crossbar_select_timers_irq;
        ADDR_ENABLE_PULLUP: next_sfr_rdata = crossbar_enable_pullup;
        default: next_sfr_rdata = RDATA_UNMAPPED;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      crossbar_select_bus_pca <= RST_SEL_BUS_PCA;
      crossbar_select_timers_irq <= RST_SEL_TIMERS_IRQ;
      crossbar_enable_pullup <= RST_ENABLE_PULLUP;
      sfr_rdata_o <= RDATA_UNMAPPED;
    end
    else
    begin
      crossbar_select_bus_pca <= next_crossbar_select_bus_pca;
      crossbar_select_timers_irq <= next_crossbar_select_timers_irq;
      crossbar_enable_pullup <= next_crossbar_enable_pullup;
      sfr_rdata_o <= next_sfr_rdata;
    end
  end

  // ****************************************************************
  // Priority decode
  // ****************************************************************
  logic [NUM_SIG-1:0] sig_en;
  logic [POS_W-1:0] pos [NUM_SIG];
  logic [POS_W-1:0] used_cnt;
  logic [NUM_PINS-1:0] sel_valid;
  logic [SIG_W-1:0] sel_idx [NUM_PINS];
  logic [NUM_PINS-1:0] pio_mask;

  assign sig_en = sig_enables(crossbar_select_bus_pca, crossbar_select_timers_irq, crossbar_enable_pullup);

  // Running slot count in rank order
  always_comb
  begin
    logic [POS_W-1:0] acc;
    acc = '0;
    for (int i = 0; i < NUM_SIG; i++)
    begin
      pos[i] = acc;
      acc = acc + POS_W'(sig_en[i]);
    end
    used_cnt = acc;
  end

  // Map each pin slot back to its signal; same for any package
  always_comb
  begin
    for (int p = 0; p < NUM_PINS; p++)
    begin
      sel_valid[p] = 1'b0;
      sel_idx[p] = '0;
      for (int i = 0; i < NUM_SIG; i++)
      begin
        if (p < XBAR_PINS && sig_en[i] && pos[i] == POS_W'(p))
        begin
          sel_valid[p] = 1'b1;
          sel_idx[p] = SIG_W'(i);
        end
      end
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  logic [NUM_PINS-1:0] next_pin_out;
  logic [NUM_PINS-1:0] next_pin_oe;
  logic [NUM_PINS-1:0] next_pin_pullup;
  logic [NUM_SIG-1:0] next_periph_in;
  pcx_pin_if pin_if ();

  assign pin_if.raw = pin_in_i;

  // Per-pin driver style and data
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++)
    begin : g_pin
      logic forced_od;
      logic open_drain;
      logic dat;
      logic want;
      assign forced_od = sel_valid[gp] && (sel_idx[gp] == SIG_W'(SIG_SDA) || sel_idx[gp] == SIG_W'(SIG_SCL)
                         || (sel_idx[gp] == SIG_W'(SIG_RX) && uart_mode0_i));
      assign open_drain = ~port_driver_config_i[gp] | forced_od;
      assign dat = sel_valid[gp] ? periph_out_i[sel_idx[gp]] : port_latch_i[gp];
      assign want = sel_valid[gp] ? periph_oe_i[sel_idx[gp]] : 1'b1;
      assign next_pin_oe[gp] = crossbar_global_enable & want & (~open_drain | ~dat);
      assign next_pin_out[gp] = crossbar_global_enable & want & ~open_drain & dat;
      assign next_pin_pullup[gp] = ~weak_pullup_disable & open_drain
                                   & ~(next_pin_oe[gp] & ~next_pin_out[gp]);
      assign pio_mask[gp] = (POS_W'(gp) >= used_cnt);
    end
  endgenerate

  // Routed pin levels to the peripherals, idle high otherwise
  always_comb
  begin
    for (int i = 0; i < NUM_SIG; i++)
    begin
      next_periph_in[i] = (crossbar_global_enable & sig_en[i]) ? pin_if.level[pos[i][SIG_W-1:0]] : 1'b1;
    end
  end

  // Output registers
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_out_o <= PINS_LOW;
      pin_oe_o <= PINS_LOW;
      pin_pullup_o <= PINS_HIGH;
      periph_in_o <= SIGS_HIGH;
      pin_level_o <= PINS_HIGH;
    end
    else
    begin
      pin_out_o <= next_pin_out;
      pin_oe_o <= next_pin_oe;
      pin_pullup_o <= next_pin_pullup;
      periph_in_o <= next_periph_in;
      pin_level_o <= pin_if.level;
    end
  end

  // Pin synchroniser
  pcx_pin_sync u_sync
  (
    .sys_clk_i (sys_clk_i),
    .rstn_i (rstn_i),
    .pins (pin_if.syncer)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_enable_write: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (sfr_wr_i && sfr_addr_i == ADDR_ENABLE_PULLUP) |=> crossbar_global_enable == $past(sfr_wdata_i[B2_GLOBAL_EN]))
    else $error("global enable did not follow write");

  a_enable_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !(sfr_wr_i && sfr_addr_i == ADDR_ENABLE_PULLUP) |=> $stable(crossbar_global_enable))
    else $error("global enable changed without write");

  a_off_input_mode: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !crossbar_global_enable |=> pin_oe_o == PINS_LOW)
    else $error("pin driven while crossbar disabled");

  a_mgmt_pin_place: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (crossbar_global_enable && crossbar_select_bus_pca[B0_MGMT]) |=>
    (pin_oe_o[PIN_SDA] == ($past(periph_oe_i[SIG_SDA]) & ~$past(periph_out_i[SIG_SDA])))
    && (pin_oe_o[PIN_SCL] == ($past(periph_oe_i[SIG_SCL]) & ~$past(periph_out_i[SIG_SCL]))))
    else $error("management bus not on first two pins");

  a_mgmt_open_drain: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (crossbar_global_enable && crossbar_select_bus_pca[B0_MGMT]) |=> pin_out_o[PIN_SCL:PIN_SDA] == 2'h0)
    else $error("management pin driven high");

  a_port_io_tail: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    crossbar_global_enable |=>
    ((pin_oe_o ^ ($past(port_driver_config_i) | ~$past(port_latch_i))) & $past(pio_mask)) == PINS_LOW)
    else $error("leftover pin not plain port");

  a_pullup_disable: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    weak_pullup_disable |=> pin_pullup_o == PINS_LOW)
    else $error("pull-up on while disabled");

  a_pullup_low_off: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (pin_oe_o & ~pin_out_o & pin_pullup_o) == PINS_LOW)
    else $error("pull-up on a pin driving low");

  a_level_tracks: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    ((pin_level_o ^ $past(pin_level_o)) & ~$past(pin_if.agree, 2)) == PINS_LOW)
    else $error("pin level changed before stages agreed");

  a_unselected_idle: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (~$past(sig_en) & ~periph_in_o) == '0)
    else $error("unselected function saw a pin");

endmodule : pcx_crossbar

// ---- pcx_pin_model.sv ----
`timescale 1ns/100ps
// ****************************************************************
// Package pin model
// ****************************************************************
module pcx_pin_model
(
  input wire logic sys_clk_i,
  input wire logic [31:0] pin_out_i,
  input wire logic [31:0] pin_oe_i,
  input wire logic [31:0] pin_pullup_i,
  input wire logic [31:0] ext_en_i,
  input wire logic [31:0] ext_val_i,
  output logic [31:0] pin_o
);
  logic [31:0] last = 32'h00000000;

  // Wire level: own driver, then outside source, then pull-up
  always_comb
  begin
    for (int p = 0; p < 32; p++)
    begin
      if (pin_oe_i[p])
        pin_o[p] = pin_out_i[p];
      else if (ext_en_i[p])
        pin_o[p] = ext_val_i[p];
      else if (pin_pullup_i[p])
        pin_o[p] = 1'b1;
      else
        pin_o[p] = ~last[p]; // Floating pin drifts every cycle
    end
  end

  // Previous level, so a floating pin never holds a value
  always_ff @(posedge sys_clk_i)
  begin
    last <= pin_o;
  end
endmodule : pcx_pin_model

// ---- pcx_crossbar_test.sv ----
`timescale 1ns/100ps
// ****************************************************************
// Crossbar testbench
// ****************************************************************
module pcx_crossbar_test;
  import pcx_pkg::*;
  logic clk = 1'b0;
  logic rstn_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [31:0] latch = 32'h00000000;
  logic [31:0] cfg = 32'h00000000;
  logic mode0 = 1'b0;
  logic [23:0] pout = 24'h000000;
  logic [23:0] poe = 24'h000000;
  logic [23:0] pin_fn;
  logic [31:0] pin_lvl;
  logic [31:0] pin_out;
  logic [31:0] pin_oe;
  logic [31:0] pin_pu;
  logic [31:0] level;
  logic [31:0] ext_en = 32'h00000000;
  logic [31:0] ext_val = 32'h00000000;
  logic [31:0] exp_oe;
  logic [23:0] cases [8] = '{24'h010040, 24'h110040, 24'h060040, 24'h280040,
                             24'hFFFF41, 24'hEFFF41, 24'h800441, 24'h380040};
  int bad_count = 0;
  int checks = 0;

  pcx_crossbar i_pcx_crossbar (.sys_clk_i(clk), .rstn_i(rstn_n), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .port_latch_i(latch),
    .port_driver_config_i(cfg), .uart_mode0_i(mode0), .periph_out_i(pout), .periph_oe_i(poe),
    .periph_in_o(pin_fn), .pin_in_i(pin_lvl), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
    .pin_pullup_o(pin_pu), .pin_level_o(level));

  pcx_pin_model i_pcx_pin_model (.sys_clk_i(clk), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
    .pin_pullup_i(pin_pu), .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(pin_lvl));

  // Clock at 250 MHz
  initial
  begin
    forever #2 clk = ~clk;
  end

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    // Let one edge pass so a following write never re-raises the strobe in this time step
    @(negedge clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic cmp_vec(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_vec

  task automatic settle();
    repeat (10) @(negedge clk);
  endtask : settle

  // Program selects, drive a level pattern on all pins, check the routing
  task automatic check_map(input logic [7:0] r0, input logic [7:0] r1, input logic [7:0] r2,
                           input logic [31:0] pat);
    logic [NUM_SIG-1:0] en;
    logic [23:0] exp_in;
    int code;
    int used;
    code = int'(r0[5:3]);
    en[1:0] = {2{r0[0]}};
    en[5:2] = {4{r0[1]}};
    en[7:6] = {2{r0[2]}};
    for (int k = 0; k < PCA_SIGS; k++)
      en[SIG_CAPTURE_COMPARE_SIGNAL_0+k] = (code <= 5) && (k < code);
    en[SIG_ECI] = r0[6];
    en[SIG_CMPA] = r0[7];
    en[22:15] = r1;
    en[SIG_ADC_START] = r2[0];
    used = 0;
    for (int s = 0; s < NUM_SIG; s++)
    begin
      exp_in[s] = en[s] ? pat[used] : 1'b1;
      used += int'(en[s]);
    end
    exp_oe = PINS_HIGH << used;
    wr_reg(ADDR_SEL_BUS_PCA, r0);
    wr_reg(ADDR_SEL_TIMERS_IRQ, r1);
    wr_reg(ADDR_ENABLE_PULLUP, r2);
    latch = pat;
    ext_val = pat;
    ext_en = ~exp_oe;
    settle();
    cmp_vec(pin_oe, exp_oe);
    cmp_vec(pin_out & exp_oe, pat & exp_oe);
    cmp_vec({8'h00, pin_fn}, {8'h00, exp_in});
    cmp_vec(level, pat);
  endtask : check_map

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  // Watchdog against a hang
  initial
  begin
    #100000;
    bad_count++;
    results();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    logic [7:0] d;
    repeat (10) @(negedge clk);
    rstn_n = 1'b1;
    @(negedge clk);
    // Reset state and register access
    cmp_vec(pin_oe, PINS_LOW);
    cmp_vec(pin_pu, PINS_HIGH);
    for (int a = 0; a < 3; a++)
    begin
      rd_reg(ADDR_SEL_BUS_PCA + 8'(a), d);
      cmp_reg(d, 8'h00);
    end
    wr_reg(ADDR_SEL_BUS_PCA, 8'hFF);
    rd_reg(ADDR_SEL_BUS_PCA, d);
    cmp_reg(d, 8'hFF);
    wr_reg(ADDR_ENABLE_PULLUP, 8'hFF);
    rd_reg(ADDR_ENABLE_PULLUP, d);
    cmp_reg(d, ENABLE_PULLUP_RW_MASK);
    wr_reg(8'hE0, 8'h55);
    rd_reg(8'hE0, d);
    cmp_reg(d, RDATA_UNMAPPED);
    // Selects set but crossbar off: all pins input
    cfg = PINS_HIGH;
    wr_reg(ADDR_SEL_TIMERS_IRQ, 8'hFF);
    wr_reg(ADDR_ENABLE_PULLUP, 8'h01);
    settle();
    cmp_vec(pin_oe, PINS_LOW);
    // Routing table and every counter-array code
    for (int i = 0; i < 8; i++)
      check_map(cases[i][23:16], cases[i][15:8], cases[i][7:0], 32'h9E3779B9 * (i + 1));
    for (int c = 0; c < 8; c++)
      check_map({2'b00, 3'(c), 3'b001}, 8'h00, 8'h41, 32'h5A3C96E1 ^ (c * 32'h01010101));
    // Driver style, forced open-drain and pull-ups
    ext_en = PINS_LOW;
    cfg = PINS_LOW;
    latch = 32'hFFFF0000;
    poe = 24'h000003;
    pout = 24'h000002;
    wr_reg(ADDR_SEL_BUS_PCA, 8'h01);
    wr_reg(ADDR_SEL_TIMERS_IRQ, 8'h00);
    wr_reg(ADDR_ENABLE_PULLUP, 8'h40);
    settle();
    exp_oe = {~latch[31:2], 2'b01};
    cmp_vec(pin_oe, exp_oe);
    cmp_vec(pin_out, PINS_LOW);
    cmp_vec(pin_pu, ~exp_oe);
    cfg = PINS_HIGH;
    settle();
    cmp_vec(pin_oe, 32'hFFFFFFFD);
    cmp_vec(pin_out, {latch[31:2], 2'b00});
    cmp_vec(pin_pu, 32'h00000002);
    wr_reg(ADDR_ENABLE_PULLUP, 8'hC0);
    settle();
    cmp_vec(pin_pu, PINS_LOW);
    // Receive pin in mode 0 stays open-drain
    wr_reg(ADDR_ENABLE_PULLUP, 8'h40);
    wr_reg(ADDR_SEL_BUS_PCA, 8'h04);
    mode0 = 1'b1;
    poe = 24'h000080;
    pout = 24'h000080;
    settle();
    cmp_vec(pin_oe & 32'h00000002, PINS_LOW);
    cmp_vec(pin_pu & 32'h00000002, 32'h00000002);
    results();
  end
endmodule : pcx_crossbar_test
